//--- radio_modem_low_power_wake_control.sv
// low power sequencer with ahb-lite register slave
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module radio_modem_low_power_wake_control
	import wake_pkg::*;
#(
	parameter int unsigned CYC_PER_MS_P = wake_pkg::CYC_PER_MS,
	parameter int unsigned SAMPLE_CYC_P = wake_pkg::SAMPLE_CYC,
	parameter int unsigned READY_CYC_P  = wake_pkg::WAKE_READY_CYC
)(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// terminal and radio
	input  wire logic        com_rts,
	input  wire logic        setup_rts,
	input  wire logic        carrier_in,
	input  wire logic        data_decoded,
	input  wire logic        block_detected,
	input  wire logic        block_good,
	input  wire logic        tx_request,
	input  wire logic        tx_buf_nearly_full,
	// power and transmit control
	output logic             radio_power_on,
	output logic             rx_ready,
	output logic             tx_start,
	output logic      [15:0] tx_sync_ms,
	output logic             cts
);
	import wake_pkg::*;

	// synchronisers
	logic [1:0] com_s, set_s, car_s;
	logic [1:0] next_com_s, next_set_s, next_car_s;
	// registers
	logic       master, sleep_mode, data_operated_transmit_mode;
	logic [7:0] suspend_steps, act_s, extra_ms;
	logic       next_master, next_sleep_mode, next_dox;
	logic [7:0] next_suspend_steps, next_act_s, next_extra_ms;
	logic       wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	// sequencer
	pwr_e        state, next_state;
	logic [31:0] cyc, next_cyc;
	logic [31:0] ms_pre, next_ms_pre;
	logic [19:0] ms_cnt, next_ms_cnt;
	logic        seen, next_seen;
	logic [19:0] gap_ms, next_gap_ms;
	logic        gap_long, next_gap_long;
	logic        next_radio_power_on, next_rx_ready, next_tx_start, next_cts;
	logic [15:0] next_tx_sync_ms;
	// quality history
	logic [14:0] hist, next_hist;
	logic [3:0]  total, next_total;
	logic [3:0]  good_cnt;

	logic rts_any;
	logic ms_tick;

	function automatic logic [3:0] popcount15(input logic [14:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 15; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction : popcount15

	function automatic logic [19:0] act_ms(input logic [7:0] s);
		return 20'(s) * 20'd1000;
	endfunction : act_ms

	function automatic logic [19:0] susp_ms(input logic [7:0] st);
		return 20'(st) * 20'(SUSPEND_STEP_MS);
	endfunction : susp_ms

	assign good_cnt = popcount15(hist);
	// sleep wakes on rts, or on clearing sleep mode or setting master; data from the terminal never wakes
	assign rts_any  = com_s[1] | set_s[1];
	assign ms_tick  = (ms_pre == 32'(CYC_PER_MS_P - 1));

	// ---- bus slave: zero wait, write data taken in data phase
	always_comb
	begin
		next_master        = master;
		next_sleep_mode    = sleep_mode;
		next_dox           = data_operated_transmit_mode;
		next_suspend_steps = suspend_steps;
		next_act_s         = act_s;
		next_extra_ms      = extra_ms;
		next_wr_pend       = 1'b0;
		next_wr_addr       = wr_addr;
		next_hrdata        = hrdata;
		if (wr_pend)
		begin
			if (wr_addr == OFS_CTRL)
			begin
				next_master     = hwdata[CTRL_MASTER];
				next_sleep_mode = hwdata[CTRL_SLEEP];
				next_dox        = hwdata[CTRL_DOX];
			end
			else if (wr_addr == OFS_TIMING)
			begin
				// out of range values are clamped
				next_suspend_steps = (hwdata[7:0] > 8'(SUSPEND_MAX_STEPS)) ?
					8'(SUSPEND_MAX_STEPS) : hwdata[7:0];
				next_act_s = (hwdata[15:8] == 8'h00) ? 8'h01 : hwdata[15:8];
			end
			else if (wr_addr == OFS_PREAMB)
				next_extra_ms = hwdata[7:0];
		end
		if (hsel && hready && htrans == HTRANS_NONSEQ)
		begin
			next_wr_pend = hwrite;
			next_wr_addr = haddr[7:0];
			if (!hwrite)
			begin
				if (haddr[7:0] == OFS_CTRL)
					next_hrdata = {29'h0, data_operated_transmit_mode, sleep_mode, master};
				else if (haddr[7:0] == OFS_TIMING)
					next_hrdata = {16'h0, act_s, suspend_steps};
				else if (haddr[7:0] == OFS_PREAMB)
					next_hrdata = {24'h0, extra_ms};
				else if (haddr[7:0] == OFS_STATUS)
					next_hrdata = {24'h0, 1'b0, gap_long, radio_power_on, rx_ready,
						cts, 3'(state)};
				else if (haddr[7:0] == OFS_QUAL)
					next_hrdata = {24'h0, total, good_cnt};
				else
					next_hrdata = 32'h0;
			end
		end
	end

	// ---- sequencer
	always_comb
	begin
		next_com_s    = {com_s[0], com_rts};
		next_set_s    = {set_s[0], setup_rts};
		next_car_s    = {car_s[0], carrier_in};
		next_state    = state;
		next_cyc      = cyc;
		next_ms_pre   = ms_tick ? 32'h0 : ms_pre + 32'h1;
		next_ms_cnt   = ms_cnt;
		next_seen     = seen | data_decoded;
		next_gap_ms   = gap_ms;
		next_gap_long = gap_long;
		next_tx_start = 1'b0;
		next_tx_sync_ms = tx_sync_ms;
		next_cts      = !tx_buf_nearly_full;
		if (ms_tick && ms_cnt != 20'h0)
			next_ms_cnt = ms_cnt - 20'h1;
		// master preamble tracking
		if (ms_tick && !gap_long)
		begin
			if (gap_ms >= act_ms(act_s))
				next_gap_long = 1'b1;
			else
				next_gap_ms = gap_ms + 20'h1;
		end
		if (tx_request && rx_ready)
		begin
			next_tx_start = 1'b1;
			next_tx_sync_ms = 16'(extra_ms) +
				((master && gap_long && suspend_steps != 8'h0) ?
				16'(susp_ms(suspend_steps) + 20'(SYNC_MARGIN_MS)) : 16'h0);
			next_gap_ms   = 20'h0;
			next_gap_long = 1'b0;
		end
		case (state)
			ST_AWAKE:
			begin
				if (sleep_mode && !master && !rts_any)
					next_state = ST_SLEEP;
				else if (!master && suspend_steps != 8'h0 && !rts_any)
				begin
					next_state  = ST_SUSPEND;
					next_ms_cnt = susp_ms(suspend_steps);
				end
			end
			ST_SUSPEND:
			begin
				if (rts_any)
				begin
					next_state = ST_WARMUP;
					next_cyc   = 32'(READY_CYC_P);
				end
				else if (master || suspend_steps == 8'h0)
					next_state = ST_AWAKE;
				else if (ms_tick && ms_cnt <= 20'h1)
				begin
					next_state = ST_SAMPLE;
					next_cyc   = 32'(SAMPLE_CYC_P);
				end
			end
			ST_SAMPLE:
			begin
				if (car_s[1] || rts_any)
				begin
					next_state  = ST_ACTIVE;
					next_ms_cnt = act_ms(act_s);
					next_seen   = 1'b0;
				end
				else if (master)
					next_state = ST_AWAKE;
				else if (cyc <= 32'h1)
				begin
					next_state  = ST_SUSPEND;
					next_ms_cnt = susp_ms(suspend_steps);
				end
				else
					next_cyc = cyc - 32'h1;
			end
			ST_ACTIVE:
			begin
				if (ms_tick && ms_cnt <= 20'h1)
				begin
					next_seen = 1'b0;
					if (seen || car_s[1] || data_decoded || rts_any)
						next_ms_cnt = act_ms(act_s);
					else if (suspend_steps == 8'h0 || master || sleep_mode)
						next_state = ST_AWAKE;
					else
					begin
						next_state  = ST_SUSPEND;
						next_ms_cnt = susp_ms(suspend_steps);
					end
				end
			end
			ST_SLEEP:
			begin
				if (rts_any)
				begin
					next_state = ST_WARMUP;
					next_cyc   = 32'(READY_CYC_P);
				end
				else if (!sleep_mode || master)
					next_state = ST_AWAKE;
			end
			default:
			begin
				if (cyc <= 32'h1)
				begin
					next_state  = ST_ACTIVE;
					next_ms_cnt = act_ms(act_s);
					next_seen   = 1'b0;
				end
				else
					next_cyc = cyc - 32'h1;
			end
		endcase
		next_radio_power_on = (next_state != ST_SUSPEND) && (next_state != ST_SLEEP);
		next_rx_ready = (next_state == ST_AWAKE) || (next_state == ST_ACTIVE) ||
			(next_state == ST_SAMPLE);
	end

	// ---- quality window
	always_comb
	begin
		next_hist  = hist;
		next_total = total;
		if (block_detected)
		begin
			next_hist = {hist[13:0], block_good};
			if (total != 4'(QUAL_WINDOW))
				next_total = total + 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			master <= 1'b0; sleep_mode <= 1'b0; data_operated_transmit_mode <= 1'b0;
			suspend_steps <= RST_SUSPEND_STEPS; act_s <= RST_ACT_S;
			extra_ms <= RST_EXTRA_MS; wr_pend <= 1'b0; wr_addr <= 8'h00;
			hrdata <= 32'h0; com_s <= 2'h0; set_s <= 2'h0; car_s <= 2'h0;
			state <= ST_AWAKE; cyc <= 32'h0; ms_pre <= 32'h0; ms_cnt <= 20'h0;
			seen <= 1'b0; gap_ms <= 20'h0; gap_long <= 1'b1;
			radio_power_on <= 1'b1; rx_ready <= 1'b1; tx_start <= 1'b0;
			tx_sync_ms <= 16'h0; cts <= 1'b0; hist <= 15'h0; total <= 4'h0;
		end
		else if (clk_en)
		begin
			master <= next_master; sleep_mode <= next_sleep_mode; data_operated_transmit_mode <= next_dox;
			suspend_steps <= next_suspend_steps; act_s <= next_act_s;
			extra_ms <= next_extra_ms; wr_pend <= next_wr_pend; wr_addr <= next_wr_addr;
			hrdata <= next_hrdata; com_s <= next_com_s; set_s <= next_set_s;
			car_s <= next_car_s; state <= next_state; cyc <= next_cyc;
			ms_pre <= next_ms_pre; ms_cnt <= next_ms_cnt; seen <= next_seen;
			gap_ms <= next_gap_ms; gap_long <= next_gap_long;
			radio_power_on <= next_radio_power_on; rx_ready <= next_rx_ready;
			tx_start <= next_tx_start; tx_sync_ms <= next_tx_sync_ms; cts <= next_cts;
			hist <= next_hist; total <= next_total;
		end
	end

	// slave never stalls and never errors
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule : radio_modem_low_power_wake_control

`default_nettype wire

//--- wake_pkg.sv
// constants for the radio modem low power wake controller
package wake_pkg;
	localparam int unsigned CLK_HZ            = 200_000_000;
	localparam int unsigned CYC_PER_MS        = CLK_HZ / 1000;
	localparam int unsigned SAMPLE_MS         = 100;
	localparam int unsigned SAMPLE_CYC        = SAMPLE_MS * CYC_PER_MS;
	localparam int unsigned WAKE_READY_MIN_MS = 45;
	localparam int unsigned WAKE_READY_MAX_MS = 65;
	localparam int unsigned WAKE_READY_MS     = 55;
	localparam int unsigned WAKE_READY_CYC    = WAKE_READY_MS * CYC_PER_MS;
	localparam int unsigned SUSPEND_STEP_MS   = 50;
	localparam int unsigned SUSPEND_MAX_STEPS = 240;
	localparam int unsigned ACT_MAX_S         = 255;
	localparam int unsigned QUAL_WINDOW       = 15;
	localparam int unsigned SYNC_MARGIN_MS    = 5;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_TIMING  = 8'h04;
	localparam logic [7:0] OFS_PREAMB  = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0c;
	localparam logic [7:0] OFS_QUAL    = 8'h10;
	// ctrl fields
	localparam int unsigned CTRL_MASTER = 0;
	localparam int unsigned CTRL_SLEEP  = 1;
	localparam int unsigned CTRL_DOX    = 2;
	// reset values, bus transfer code and states
	localparam logic [7:0] RST_SUSPEND_STEPS = 8'h00;
	localparam logic [7:0] RST_ACT_S         = 8'h01;
	localparam logic [7:0] RST_EXTRA_MS      = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ     = 2'h2;
	typedef enum logic [2:0] {ST_AWAKE, ST_ACTIVE, ST_SUSPEND, ST_SAMPLE, ST_SLEEP,
		ST_WARMUP} pwr_e;
endpackage : wake_pkg

//--- wake_checker.sv
// port checker for the wake controller
`timescale 1ns/1ps
`default_nettype none
module wake_checker (
	// bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	// terminal and radio
	input wire logic com_rts,
	input wire logic setup_rts,
	input wire logic tx_request,
	input wire logic tx_buf_nearly_full,
	input wire logic radio_power_on,
	input wire logic rx_ready,
	input wire logic tx_start,
	input wire logic cts
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rts_held;
		(com_rts || setup_rts) [*8];
	endsequence
	sequence s_quiet_drop;
		$fell(radio_power_on) && !com_rts && !setup_rts;
	endsequence
	property p_bus_ok; hreadyout && !hresp; endproperty
	a_bus_ok: assert property (p_bus_ok)
		else $error("bus stalled or erred");
	property p_cts_drop; $rose(tx_buf_nearly_full) |=> !cts; endproperty
	a_cts_drop: assert property (p_cts_drop)
		else $error("cts kept high with buffer full");
	property p_cts_rise; $fell(tx_buf_nearly_full) |=> cts; endproperty
	a_cts_rise: assert property (p_cts_rise)
		else $error("cts not restored");
	property p_tx_pulse; tx_start |=> !tx_start; endproperty
	a_tx_pulse: assert property (p_tx_pulse)
		else $error("transmit start longer than one cycle");
	property p_tx_cause; tx_start |-> $past(tx_request) && $past(rx_ready); endproperty
	a_tx_cause: assert property (p_tx_cause)
		else $error("transmit without request");
	property p_power_ready; !radio_power_on |-> !rx_ready; endproperty
	a_power_ready: assert property (p_power_ready)
		else $error("ready while powered down");
	property p_rts_awake; s_rts_held |-> radio_power_on; endproperty
	a_rts_awake: assert property (p_rts_awake)
		else $error("asleep with rts held");
	property p_quiet_hold; s_quiet_drop |=> !radio_power_on [*2]; endproperty
	a_quiet_hold: assert property (p_quiet_hold)
		else $error("woke at once without cause");
endmodule : wake_checker
`default_nettype wire

//--- rts_terminal.sv
// terminal model driving the rts lines
`timescale 1ns/1ps
`default_nettype none
module rts_terminal (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// bench requests
	input  wire logic want_com,
	input  wire logic want_setup,
	// handshake lines
	output var logic  com_rts,
	output var logic  setup_rts
);
	// lines move just after an edge, never mid-cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			com_rts   <= 1'b0;
			setup_rts <= 1'b0;
		end
		else
		begin
			com_rts   <= want_com;
			setup_rts <= want_setup;
		end
	end
endmodule : rts_terminal
`default_nettype wire

//--- radio_modem_low_power_wake_control_bench.sv
// self-checking bench for the wake controller
`timescale 1ns/1ps
`default_nettype none
module radio_modem_low_power_wake_control_bench;
	import wake_pkg::*;
	localparam int CPM = 10;
	localparam int SMP = 20;
	localparam int RDY = 30;
	localparam int SUS = SUSPEND_STEP_MS * CPM;
	localparam int ACT = 1000 * CPM;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cts;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic        carrier_in, block_detected, block_good, tx_request, full;
	logic        data_decoded, en;
	logic        com_rts, setup_rts, want_com, want_setup;
	logic        radio_power_on, rx_ready, tx_start;
	logic [15:0] tx_sync_ms;
	int          err_total, checks, n;
	rts_terminal rts_terminal_inst (.hclk(hclk), .hresetn(hresetn), .want_com(want_com),
		.want_setup(want_setup), .com_rts(com_rts), .setup_rts(setup_rts));
	radio_modem_low_power_wake_control #(.CYC_PER_MS_P(CPM), .SAMPLE_CYC_P(SMP),
		.READY_CYC_P(RDY)) radio_modem_low_power_wake_control_inst (.hclk(hclk),
		.hresetn(hresetn), .clk_en(en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .com_rts(com_rts),
		.setup_rts(setup_rts), .carrier_in(carrier_in), .data_decoded(data_decoded),
		.block_detected(block_detected), .block_good(block_good), .tx_request(tx_request),
		.tx_buf_nearly_full(full), .radio_power_on(radio_power_on), .rx_ready(rx_ready),
		.tx_start(tx_start), .tx_sync_ms(tx_sync_ms), .cts(cts));
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task results;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task rng(input string nm, input int lo, input int hi);
		checks++;
		if (n < lo || n > hi)
		begin
			err_total++;
			$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask : rng
	function logic sig(input int k);
		return k == 0 ? rx_ready : k == 1 ? radio_power_on : tx_start;
	endfunction : sig
	// counts edges until the chosen output settles at v
	task await(input int k, input logic v, input int lim);
		n = 0;
		while (sig(k) !== v)
		begin
			@(posedge hclk);
			#1;
			n++;
			if (n > lim)
			begin
				$display("FAIL wait %0d expected %b seen %b", k, v, sig(k));
				err_total++;
				results();
			end
		end
	endtask : await
	task rdy;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			$display("FAIL hready expected 1 seen %b", hreadyout);
			err_total++;
			results();
		end
	endtask : rdy
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		if (!w)
			chk("hrdata", e, hrdata);
	endtask : bus
	task tx(input logic [15:0] e);
		@(posedge hclk);
		tx_request <= 1'b1;
		@(posedge hclk);
		tx_request <= 1'b0;
		#1;
		await(2, 1'b1, 3);
		chk("tx_sync_ms", {16'h0, e}, {16'h0, tx_sync_ms});
	endtask : tx
	initial
	begin
		{hresetn, hsel, hwrite, carrier_in, block_detected, block_good} = 6'h0;
		{tx_request, full, want_com, want_setup, haddr, hwdata, htrans} = 0;
		data_decoded = 1'b0;
		en = 1'b1;
		err_total = 0;
		checks = 0;
		repeat (5) @(posedge hclk);
		chk("reset outputs", 32'hc, {28'h0, rx_ready, radio_power_on, cts, tx_start});
		hresetn <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0, 32'h0);
		bus(1'b0, OFS_TIMING, 32'h0, 32'h100);
		bus(1'b1, 8'h20, 32'hffffffff, 32'h0);
		bus(1'b0, 8'h20, 32'h0, 32'h0);
		@(posedge hclk);
		full <= 1'b1;
		repeat (3) @(posedge hclk);
		full <= 1'b0;
		#1;
		chk("cts", 32'h0, {31'h0, cts});
		@(posedge hclk);
		#1;
		chk("cts", 32'h1, {31'h0, cts});
		bus(1'b1, OFS_PREAMB, 32'h8, 32'h0);
		bus(1'b1, OFS_TIMING, 32'h101, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h1, 32'h0);
		repeat (SUS + 100) @(posedge hclk);
		chk("master power", 32'h1, {31'h0, radio_power_on});
		tx(16'(SUSPEND_STEP_MS + SYNC_MARGIN_MS + 8));
		tx(16'h8);
		repeat (ACT + 200) @(posedge hclk);
		tx(16'(SUSPEND_STEP_MS + SYNC_MARGIN_MS + 8));
		bus(1'b1, OFS_CTRL, 32'h0, 32'h0);
		await(1, 1'b0, 50);
		await(0, 1'b1, SUS + 50);
		rng("suspend cycles", SUS - 20, SUS + 20);
		await(0, 1'b0, SMP + 20);
		rng("sample cycles", SMP - 5, SMP + 5);
		await(0, 1'b1, SUS + 50);
		@(posedge hclk);
		carrier_in <= 1'b1;
		repeat (30) @(posedge hclk);
		carrier_in <= 1'b0;
		await(1, 1'b0, ACT + 100);
		rng("activity cycles", ACT - 100, ACT + 50);
		await(0, 1'b1, SUS + 50);
		@(posedge hclk);
		carrier_in <= 1'b1;
		repeat (ACT + ACT / 4) @(posedge hclk);
		carrier_in <= 1'b0;
		#1;
		chk("restarted awake", 32'h1, {31'h0, rx_ready});
		// decoded data inside the interval earns one more full interval
		@(posedge hclk);
		data_decoded <= 1'b1;
		@(posedge hclk);
		data_decoded <= 1'b0;
		await(1, 1'b0, 2 * ACT + 100);
		rng("data restart cycles", ACT + ACT / 2, 2 * ACT);
		@(posedge hclk);
		want_com <= 1'b1;
		repeat (SUS * 2) @(posedge hclk);
		want_com <= 1'b0;
		#1;
		chk("rts awake", 32'h3, {30'h0, radio_power_on, rx_ready});
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, OFS_CTRL, k ? 32'h6 : 32'h2, 32'h0);
			await(1, 1'b0, ACT + 100);
			@(posedge hclk);
			carrier_in <= 1'b1;
			repeat (SUS * 2) @(posedge hclk);
			carrier_in <= 1'b0;
			want_com <= k[0];
			want_setup <= !k[0];
			#1;
			chk("sleep power", 32'h0, {31'h0, radio_power_on});
			await(0, 1'b1, RDY + 20);
			rng("warmup cycles", RDY, RDY + 10);
			@(posedge hclk);
			{want_com, want_setup} <= 2'h0;
		end
		for (int i = 0; i < 17; i++)
		begin
			@(posedge hclk);
			block_detected <= 1'b1;
			block_good <= (i < 3);
			@(posedge hclk);
			block_detected <= 1'b0;
		end
		// blocks offered while frozen must not be counted
		@(posedge hclk);
		en <= 1'b0;
		block_detected <= 1'b1;
		block_good <= 1'b1;
		repeat (2) @(posedge hclk);
		en <= 1'b1;
		block_detected <= 1'b0;
		bus(1'b0, OFS_QUAL, 32'h0, 32'hf1);
		results();
	end
endmodule : radio_modem_low_power_wake_control_bench
bind radio_modem_low_power_wake_control wake_checker wake_checker_inst (.hclk(hclk),
	.hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .com_rts(com_rts),
	.setup_rts(setup_rts), .tx_request(tx_request), .tx_buf_nearly_full(tx_buf_nearly_full),
	.radio_power_on(radio_power_on), .rx_ready(rx_ready), .tx_start(tx_start), .cts(cts));
`default_nettype wire
